// [design/drive_security_pkg.sv]
// constants and types for the drive security command block
package drive_security_pkg;

  // register byte addresses on the apb bus
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_DRIVE_SELECT = 8'h04;
  localparam logic [7:0] ADDR_ERROR = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  localparam logic [7:0] ADDR_SEC_STATE = 8'h14;
  localparam logic [7:0] ADDR_REV_CODE = 8'h18;
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h1c;

  // command opcodes
  localparam logic [7:0] OP_SET_PASSWORD = 8'hf1;
  localparam logic [7:0] OP_UNLOCK = 8'hf2;
  localparam logic [7:0] OP_ERASE_PREPARE = 8'hf3;
  localparam logic [7:0] OP_ERASE_UNIT = 8'hf4;
  localparam logic [7:0] OP_FREEZE = 8'hf5;
  localparam logic [7:0] OP_DISABLE_PASSWORD = 8'hf6;

  // status and error bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_SEEK_DONE = 4;
  localparam int ST_DATA_REQ = 3;
  localparam int ST_ERROR = 0;
  localparam int ERR_ABORT = 2;

  // payload layout
  localparam int PAYLOAD_WORDS = 256;
  localparam int PW_FIRST_WORD = 1;
  localparam int PW_WORDS = 16;
  localparam int REV_WORD = 17;
  localparam int CTL_SELECT_BIT = 0;
  localparam int CTL_LEVEL_BIT = 8;
  localparam logic [15:0] REV_LOW_INVALID = 16'h0000;
  localparam logic [15:0] REV_HIGH_INVALID = 16'hffff;
  localparam logic [15:0] REV_RESET = 16'h0000;

  // power control bits
  localparam int PWR_ON_EVENT_BIT = 0;
  localparam int PWR_HARD_RESET_BIT = 1;

  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h50;
  localparam logic [7:0] ERROR_RESET = 8'h00;
  localparam logic [7:0] DRIVE_SELECT_RESET = 8'ha0;

  // security flags as seen by the decoder and by software
  typedef struct packed {
    logic user_set;
    logic master_set;
    logic level_max;
    logic enabled;
    logic locked;
    logic frozen;
  } sec_state_type;

  localparam sec_state_type SEC_RESET = '{default: 1'b0};

endpackage

// [design/drive_security_freeze_setpw.sv]
// freeze and set-password command handling behind an apb register file
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module drive_security_freeze_setpw #(
  parameter int PAYLOAD_LEN = drive_security_pkg::PAYLOAD_WORDS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import drive_security_pkg::*;

  typedef enum logic [1:0] {
    IDLE_ST = 2'b00,
    PAYLOAD_ST = 2'b01
  } phase_type;

  //////////////////////////////////////////////////////////////////////////////
  // state

  phase_type phase;
  sec_state_type sec;
  logic [7:0] drive_select;
  logic [7:0] error_report;
  logic [7:0] drive_status;
  logic [7:0] command_opcode;
  logic [15:0] rev_code;
  logic [8:0] word_count;
  logic [15:0] ctl_word;
  logic [15:0] pw_buf [PW_WORDS];
  logic [15:0] user_pw [PW_WORDS];
  logic [15:0] master_pw [PW_WORDS];
  logic [15:0] new_rev;
  logic erase_armed;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  function automatic logic [7:0] status_word(input logic err, input logic drq);
    logic [7:0] s;
    s = 8'h00;
    s[ST_READY] = 1'b1;
    s[ST_SEEK_DONE] = 1'b1;
    s[ST_DATA_REQ] = drq;
    s[ST_ERROR] = err;
    return s;
  endfunction

  wire logic xfer = psel & penable & pready;
  wire logic wr = xfer & pwrite;
  wire logic lane0 = pstrb[0];
  wire logic wr_cmd = wr & lane0 & (paddr == ADDR_COMMAND);
  wire logic wr_sel = wr & lane0 & (paddr == ADDR_DRIVE_SELECT);
  wire logic wr_data = wr & (pstrb[1:0] == 2'b11) & (paddr == ADDR_DATA);
  wire logic wr_pwr = wr & lane0 & (paddr == ADDR_POWER_CTRL);
  wire logic power_on = wr_pwr & pwdata[PWR_ON_EVENT_BIT];
  wire logic hard_reset = wr_pwr & pwdata[PWR_HARD_RESET_BIT] & ~power_on;
  wire logic addr_ok = (paddr[1:0] == 2'b00) & (paddr <= ADDR_POWER_CTRL);
  wire logic ro_addr = (paddr == ADDR_ERROR) | (paddr == ADDR_STATUS) |
                       (paddr == ADDR_SEC_STATE) | (paddr == ADDR_REV_CODE);
  wire logic wo_addr = (paddr == ADDR_DATA) | (paddr == ADDR_POWER_CTRL);
  wire logic bad_access = ~addr_ok | (pwrite & ro_addr) | (~pwrite & wo_addr);

  logic [31:0] read_mux;
  always_comb begin
    read_mux = 32'h0000_0000;
    case (paddr)
      ADDR_DRIVE_SELECT: read_mux = {24'h00_0000, drive_select};
      ADDR_ERROR: read_mux = {24'h00_0000, error_report};
      ADDR_STATUS: read_mux = {24'h00_0000, drive_status};
      ADDR_SEC_STATE: read_mux = {26'h000_0000, sec};
      ADDR_REV_CODE: read_mux = {16'h0000, rev_code};
      ADDR_COMMAND: read_mux = {24'h00_0000, command_opcode};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // command decode

  wire logic [7:0] op = pwdata[7:0];
  wire logic op_freeze = wr_cmd & (op == OP_FREEZE);
  wire logic op_setpw = wr_cmd & (op == OP_SET_PASSWORD);
  wire logic op_changer = (op == OP_SET_PASSWORD) | (op == OP_UNLOCK) |
                          (op == OP_DISABLE_PASSWORD) | (op == OP_ERASE_UNIT);
  wire logic op_prepare = wr_cmd & (op == OP_ERASE_PREPARE) & ~sec.frozen;
  // frozen flag consulted before any security-state change
  wire logic frozen_reject = wr_cmd & op_changer & sec.frozen;
  wire logic accept_setpw = op_setpw & ~sec.frozen;
  // unlock, disable and erase are served elsewhere; here they abort
  wire logic abort_cmd = wr_cmd & ~op_freeze & ~accept_setpw & ~op_prepare;

  wire logic last_word = (word_count == 9'(PAYLOAD_LEN - 1));
  wire logic take_word = wr_data & (phase == PAYLOAD_ST);
  wire logic commit = take_word & last_word;
  wire logic is_master = ctl_word[CTL_SELECT_BIT];
  wire logic is_max = ctl_word[CTL_LEVEL_BIT];
  wire logic [15:0] data_word = pwdata[15:0];
  // a short sector may end on the revision word itself, so bypass the buffer
  wire logic rev_now = take_word & (word_count == 9'(REV_WORD));
  wire logic [15:0] rev_in = rev_now ? data_word : new_rev;
  wire logic rev_valid = (rev_in != REV_LOW_INVALID) & (rev_in != REV_HIGH_INVALID);

  //////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, answer registered

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      prdata <= (psel & penable & ~pready & ~pwrite & ~bad_access) ? read_mux : 32'h0000_0000;
      pslverr <= psel & penable & ~pready & bad_access;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // task-file registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_select <= DRIVE_SELECT_RESET;
      command_opcode <= 8'h00;
    end else begin
      if (wr_sel) begin
        drive_select <= pwdata[7:0];
      end
      if (wr_cmd) begin
        command_opcode <= op;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_report <= ERROR_RESET;
      drive_status <= STATUS_RESET;
    end else if (power_on | hard_reset) begin
      error_report <= ERROR_RESET;
      drive_status <= STATUS_RESET;
    end else if (abort_cmd | frozen_reject) begin
      error_report <= 8'h01 << ERR_ABORT;
      drive_status <= status_word(1'b1, 1'b0);
    end else if (wr_cmd) begin
      error_report <= ERROR_RESET;
      // freeze completes without data; set-password raises data request
      drive_status <= status_word(1'b0, accept_setpw);
    end else if (commit) begin
      drive_status <= status_word(1'b0, 1'b0);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // payload sequencing

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= IDLE_ST;
      word_count <= 9'h000;
    end else if (power_on | hard_reset) begin
      phase <= IDLE_ST;
      word_count <= 9'h000;
    end else if (wr_cmd) begin
      // a new command abandons any payload in flight
      phase <= accept_setpw ? PAYLOAD_ST : IDLE_ST;
      word_count <= 9'h000;
    end else if (take_word) begin
      phase <= last_word ? IDLE_ST : PAYLOAD_ST;
      word_count <= last_word ? 9'h000 : word_count + 9'h001;
    end
  end

  // words are buffered so an abandoned sector never touches stored passwords
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_word <= 16'h0000;
      new_rev <= 16'h0000;
    end else if (take_word) begin
      if (word_count == 9'h000) begin
        ctl_word <= data_word;
      end
      if (word_count == 9'(REV_WORD)) begin
        new_rev <= data_word;
      end
    end
  end

  always_ff @(posedge pclk) begin
    for (int i = 0; i < PW_WORDS; i++) begin
      if (take_word && word_count == 9'(PW_FIRST_WORD + i)) begin
        pw_buf[i] <= data_word;
      end
    end
  end

  // stored passwords carry no reset; they stand for nonvolatile media
  always_ff @(posedge pclk) begin
    for (int i = 0; i < PW_WORDS; i++) begin
      if (commit && !is_master) begin
        user_pw[i] <= pw_buf[i];
      end
      if (commit && is_master) begin
        master_pw[i] <= pw_buf[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // security flags

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec <= SEC_RESET;
      rev_code <= REV_RESET;
      erase_armed <= 1'b0;
    end else begin
      if (power_on) begin
        sec.frozen <= 1'b0;
        // lock takes hold only here, never at set-password time
        sec.locked <= sec.enabled;
      end else if (op_freeze) begin
        sec.frozen <= 1'b1;
      end
      if (commit && !is_master) begin
        sec.enabled <= 1'b1;
        sec.level_max <= is_max;
        sec.user_set <= 1'b1;
      end
      if (commit && is_master) begin
        sec.master_set <= 1'b1;
        if (rev_valid) begin
          rev_code <= rev_in;
        end
      end
      // prepare arms erase for the very next command only
      if (power_on | hard_reset) begin
        erase_armed <= 1'b0;
      end else if (wr_cmd) begin
        erase_armed <= op_prepare;
      end
    end
  end

endmodule // drive_security_freeze_setpw

// [verification/drive_security_host.sv]
// apb host model standing in for the task-file controller
`timescale 1ns/1ps
module drive_security_host (
  // clock
  input wire logic pclk,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // wait limit ran out
  output logic hang
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    hang = 1'b0;
  end
  // entered just after a rising edge; returns one idle cycle after the answer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look mid-cycle: at the rising edge the answer is still being launched
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    // hold the request through the edge that samples ready high
    @(posedge pclk);
    // released lines show the inverse so stale values are never trusted
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= ~w;
    paddr <= ~a;
    pwdata <= ~d;
    if (n >= 50)
      hang <= 1'b1;
    @(posedge pclk);
  endtask
endmodule // drive_security_host

// [verification/drive_security_freeze_setpw_sva.sv]
// port-level checks for the security command block
`timescale 1ns/1ps
module drive_security_freeze_setpw_sva
  import drive_security_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic frz;
  wire take = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // freeze survives everything but a power-on event
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      frz <= 1'b0;
    else if (take && paddr == ADDR_COMMAND && pwdata[7:0] == OP_FREEZE)
      frz <= 1'b1;
    else if (take && paddr == ADDR_POWER_CTRL && pwdata[PWR_ON_EVENT_BIT])
      frz <= 1'b0;
  a_one_wait: assert property (psel && !penable |=> !pready ##1 pready) else $error("ready not after one wait");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
  a_err_clean: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
  a_align_err: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr) else $error("misaligned not refused");
  a_ro_write: assert property (pready && pwrite && (paddr == ADDR_STATUS || paddr == ADDR_ERROR) |-> pslverr)
    else $error("read-only write not refused");
  a_busy_clear: assert property (pready && !pwrite && paddr == ADDR_STATUS |-> !prdata[ST_BUSY])
    else $error("busy seen set");
  a_frozen_shown: assert property (pready && !pwrite && paddr == ADDR_SEC_STATE |-> prdata[0] == frz)
    else $error("frozen flag wrong");
endmodule // drive_security_freeze_setpw_sva
bind drive_security_freeze_setpw drive_security_freeze_setpw_sva u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

// [verification/drive_security_freeze_setpw_tb_top.sv]
// self-checking bench for the freeze and set-password block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module drive_security_freeze_setpw_tb_top;
  import drive_security_pkg::*;
  localparam int PLEN = 18;
  logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, hang;
  logic [7:0] paddr, st = 8'h50, er = 8'h00;
  logic [31:0] pwdata, prdata, r, seed = 32'h9e89718f;
  logic [3:0] pstrb;
  logic [15:0] rev = 16'h0;
  logic e, frozen = 0, enabled = 0, user_set = 0, master_set = 0, level_max = 0, locked = 0, pend = 0;
  int n_fail = 0, checks_done = 0;
  logic [15:0] rcs [6] = '{16'h0001, 16'h1234, 16'hffff, 16'h5678, 16'h0000, 16'h9abc};
  logic [7:0] ops [5] = '{OP_UNLOCK, OP_ERASE_UNIT, OP_DISABLE_PASSWORD, 8'h90, OP_ERASE_PREPARE};
  always #2 pclk = ~pclk;
  drive_security_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hang(hang));
  drive_security_freeze_setpw #(.PAYLOAD_LEN(PLEN)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic x;
    host.xfer(1'b0, a, 32'h0, v, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic x;
    host.xfer(1'b1, a, d, v, x);
    `CHK("write_refused", 1'b0, x)
  endtask
  task automatic check();
    logic [31:0] v;
    rd(ADDR_STATUS, v); `CHK("status", {24'h0, st}, v)
    rd(ADDR_ERROR, v); `CHK("error", {24'h0, er}, v)
    rd(ADDR_SEC_STATE, v); `CHK("sec_state", {26'h0, user_set, master_set, level_max, enabled, locked, frozen}, v)
    rd(ADDR_REV_CODE, v); `CHK("rev_code", {16'h0, rev}, v)
  endtask
  task automatic cmd(input logic [7:0] op);
    wr(ADDR_COMMAND, {24'h0, op});
    rd(ADDR_COMMAND, r); `CHK("command", {24'h0, op}, r)
    if (op == OP_FREEZE)
      frozen = 1'b1;
    st = 8'h51;
    er = 8'h04;
    if (op == OP_FREEZE || (!frozen && (op == OP_ERASE_PREPARE || op == OP_SET_PASSWORD))) begin
      st = (op == OP_SET_PASSWORD) ? 8'h58 : 8'h50;
      er = 8'h00;
    end
    pend = (op == OP_SET_PASSWORD) && !frozen;
    check();
  endtask
  task automatic payload(input logic sel, input logic lvl, input logic [15:0] rc, input int n);
    logic [15:0] w;
    for (int i = 0; i < n; i++) begin
      w = (i == REV_WORD) ? rc : 16'(rnd());
      if (i == 0) begin
        w[CTL_SELECT_BIT] = sel;
        w[CTL_LEVEL_BIT] = lvl;
      end
      wr(ADDR_DATA, {16'h0, w});
    end
    if (pend && n == PLEN) begin
      st = 8'h50;
      if (!sel) begin
        {enabled, user_set, level_max} = {2'b11, lvl};
      end else begin
        master_set = 1'b1;
        rev = (rc == REV_LOW_INVALID || rc == REV_HIGH_INVALID) ? rev : rc;
      end
      pend = (n != PLEN);
    end
    check();
  endtask
  task automatic pwr(input logic [1:0] b);
    wr(ADDR_POWER_CTRL, {30'h0, b});
    {pend, st, er} = {1'b0, 8'h50, 8'h00};
    if (b[0])
      {frozen, locked} = {1'b0, enabled};
    check();
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge hang) begin
    n_fail++;
    give_verdict();
  end
  ////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check();
    rd(ADDR_DRIVE_SELECT, r); `CHK("drive_select", 32'ha0, r)
    wr(ADDR_DRIVE_SELECT, rnd());
    rd(ADDR_DRIVE_SELECT, r); `CHK("drive_select", {24'h0, seed[7:0]}, r)
    host.xfer(1'b0, 8'h22, 32'h0, r, e); `CHK("unmapped", 1'b1, e)
    host.xfer(1'b1, ADDR_STATUS, 32'h0, r, e); `CHK("ro_write", 1'b1, e)
    wr(ADDR_DATA, rnd());
    check();
    $display("test registers done");
    // master first, then alternate power-on and hard reset
    for (int k = 0; k < 6; k++) begin
      cmd(OP_SET_PASSWORD);
      payload(!k[0], k[1], rcs[k], PLEN);
      pwr({k[0], ~k[0]});
    end
    $display("test set password done");
    cmd(OP_SET_PASSWORD);
    payload(1'b0, 1'b1, 16'h0, 3);
    foreach (ops[i]) cmd(ops[i]);
    $display("test abort and abandon done");
    cmd(OP_FREEZE);
    for (int i = 0; i < 3; i++) cmd(ops[i]);
    cmd(OP_SET_PASSWORD);
    payload(1'b0, 1'b1, 16'h0, PLEN);
    pwr(2'b10);
    cmd(OP_SET_PASSWORD);
    pwr(2'b01);
    cmd(OP_SET_PASSWORD);
    payload(1'b0, 1'b1, 16'h0, PLEN);
    $display("test freeze done");
    give_verdict();
  end
endmodule // drive_security_freeze_setpw_tb_top
